// ### logic/ieesr_pkg.sv
// Package for the status-reporting and common-command block.
// Assumes a single instrument clock; shared by the design and its bench.
package ieesr_pkg;

  // ---------------------------------------------------------------
  // Event status latch bit positions and power-on value
  // ---------------------------------------------------------------
  localparam int unsigned EVT_OPC = 0;
  localparam int unsigned EVT_QRY = 2;
  localparam int unsigned EVT_DEV = 3;
  localparam int unsigned EVT_EXE = 4;
  localparam int unsigned EVT_CMD = 5;
  localparam int unsigned EVT_PON = 7;
  localparam logic [7:0] EVT_RESET = 8'h80;
  localparam logic [7:0] EVT_USED = 8'hbd;

  // ---------------------------------------------------------------
  // Summary status byte bit positions
  // ---------------------------------------------------------------
  localparam int unsigned STB_MAV = 4;
  localparam int unsigned STB_ESB = 5;
  localparam int unsigned STB_MSS = 6;

  // ---------------------------------------------------------------
  // Reset values, self-test answers and queue geometry
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic PSC_RESET = 1'b1;
  localparam logic [7:0] TST_PASS = 8'h00;
  localparam logic [7:0] TST_NVM_FAIL = 8'h01;
  localparam logic [7:0] OPC_DONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int unsigned QUE_DEPTH = 4;
  localparam int unsigned QUE_AW = 2;

  // ---------------------------------------------------------------
  // Common command codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IEESR_CMD_CLS   = 4'h0,
    IEESR_CMD_OPC   = 4'h1,
    IEESR_CMD_OPC_Q = 4'h2,
    IEESR_CMD_WAI   = 4'h3,
    IEESR_CMD_RST   = 4'h4,
    IEESR_CMD_TST_Q = 4'h5,
    IEESR_CMD_ESR_Q = 4'h6,
    IEESR_CMD_ESE_W = 4'h7,
    IEESR_CMD_ESE_Q = 4'h8,
    IEESR_CMD_STB_Q = 4'h9,
    IEESR_CMD_SRE_W = 4'ha,
    IEESR_CMD_SRE_Q = 4'hb,
    IEESR_CMD_PSC_W = 4'hc,
    IEESR_CMD_PSC_Q = 4'hd
  } ieesr_cmd_code_t;

  // One parsed command from the interface parser.
  typedef struct packed {
    logic valid;
    logic unknown;
    logic [3:0] code;
    logic [7:0] arg;
  } ieesr_cmd_t;

  // Event pulses from the instrument.
  typedef struct packed {
    logic dev_err;
    logic exec_err;
    logic syntax_err;
    logic test_ok;
    logic power_on;
  } ieesr_evt_t;

  // One byte handed back to the bus side.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ieesr_rsp_t;

endpackage

// ### logic/ieesr_status.sv
// Status reporting and common-command execution for a bus instrument.
// Assumes a parser on the same clock hands over decoded commands, and
// the instrument reports its events as one-cycle pulses on this clock.

`timescale 1ns/1ps

module ieesr_status (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Decoded common commands.
  input wire ieesr_pkg::ieesr_cmd_t cmd,
  // Instrument events and self-test outcome.
  input wire ieesr_pkg::ieesr_evt_t evt,
  input wire logic nvm_fail,
  // Response queue read side.
  input wire logic rsp_rd,
  output ieesr_pkg::ieesr_rsp_t rsp_ff,
  // Status registers seen by the instrument.
  output logic [7:0] event_status_latch_ff,
  output logic [7:0] event_status_mask_ff,
  output logic [7:0] summary_status_byte_ff,
  output logic [7:0] service_request_mask_ff,
  output logic power_on_clear_ff,
  output logic service_req_ff
);

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------

  logic is_cls;
  logic is_opc;
  logic is_rst;
  logic is_esr_q;
  logic is_ese_w;
  logic is_sre_w;
  logic is_psc_w;
  logic psc_bad;
  logic push_req;
  logic [7:0] push_data;
  logic [7:0] stb_now;
  logic mss_now;

  // Known commands only count when the parser did not flag them.
  // The wait command has no decode: commands already run in order, one
  // per cycle, so there is never an earlier command left to wait for.
  assign is_cls = cmd.valid && !cmd.unknown &&
                  cmd.code == ieesr_pkg::IEESR_CMD_CLS;
  assign is_opc = cmd.valid && !cmd.unknown &&
                  cmd.code == ieesr_pkg::IEESR_CMD_OPC;
  assign is_rst = cmd.valid && !cmd.unknown &&
                  cmd.code == ieesr_pkg::IEESR_CMD_RST;
  assign is_esr_q = cmd.valid && !cmd.unknown &&
                    cmd.code == ieesr_pkg::IEESR_CMD_ESR_Q;
  assign is_ese_w = cmd.valid && !cmd.unknown &&
                    cmd.code == ieesr_pkg::IEESR_CMD_ESE_W;
  assign is_sre_w = cmd.valid && !cmd.unknown &&
                    cmd.code == ieesr_pkg::IEESR_CMD_SRE_W;
  assign is_psc_w = cmd.valid && !cmd.unknown &&
                    cmd.code == ieesr_pkg::IEESR_CMD_PSC_W;
  // The flag only takes 0 or 1; anything else cannot be executed.
  // A refused value leaves the stored flag untouched.
  assign psc_bad = is_psc_w && (cmd.arg[7:1] != 7'h00);

  // ---------------------------------------------------------------
  // Query answers
  // ---------------------------------------------------------------

  // Every query pushes one byte; the bus side formats it as decimal.
  // The completion query answers at once for the same reason the wait
  // command is empty: nothing is still running when it is taken.
  always_comb begin
    push_req = 1'b0;
    push_data = ieesr_pkg::BYTE_ZERO;
    if (cmd.valid && !cmd.unknown) begin
      case (cmd.code)
        ieesr_pkg::IEESR_CMD_TST_Q: begin
          push_req = 1'b1;
          push_data = nvm_fail ? ieesr_pkg::TST_NVM_FAIL
                               : ieesr_pkg::TST_PASS;
        end
        ieesr_pkg::IEESR_CMD_OPC_Q: begin
          push_req = 1'b1;
          push_data = ieesr_pkg::OPC_DONE;
        end
        ieesr_pkg::IEESR_CMD_ESR_Q: begin
          push_req = 1'b1;
          push_data = event_status_latch_ff;
        end
        ieesr_pkg::IEESR_CMD_ESE_Q: begin
          push_req = 1'b1;
          push_data = event_status_mask_ff;
        end
        ieesr_pkg::IEESR_CMD_STB_Q: begin
          push_req = 1'b1;
          push_data = summary_status_byte_ff;
        end
        ieesr_pkg::IEESR_CMD_SRE_Q: begin
          push_req = 1'b1;
          push_data = service_request_mask_ff;
        end
        ieesr_pkg::IEESR_CMD_PSC_Q: begin
          push_req = 1'b1;
          push_data = {7'h00, power_on_clear_ff};
        end
        default: begin
          push_req = 1'b0;
          push_data = ieesr_pkg::BYTE_ZERO;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Response output queue
  // ---------------------------------------------------------------

  logic [7:0] que_mem [ieesr_pkg::QUE_DEPTH];
  logic [ieesr_pkg::QUE_AW-1:0] wr_ptr_ff;
  logic [ieesr_pkg::QUE_AW-1:0] rd_ptr_ff;
  logic [ieesr_pkg::QUE_AW:0] count_ff;
  logic que_empty;
  logic que_full;
  logic do_push;
  logic do_pop;
  logic lost;
  logic empty_rd;

  assign que_empty = (count_ff == '0);
  assign que_full = (count_ff ==
                     (ieesr_pkg::QUE_AW+1)'(ieesr_pkg::QUE_DEPTH));
  // A read in the same cycle frees the slot, so a push then fits.
  assign do_pop = rsp_rd && !que_empty;
  assign do_push = push_req && (!que_full || do_pop);
  assign lost = push_req && !do_push;
  assign empty_rd = rsp_rd && que_empty;

  // Four slots are enough for a controller that reads each answer
  // before it asks again; a deeper queue would only hide a host that
  // forgets to read. An answer that finds no room is thrown away and
  // flagged rather than stalling the command stream.
  // Storage has no reset; only slots below the count are ever read.
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      que_mem[wr_ptr_ff] <= push_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Read data is held until the next pop; valid pulses for one cycle.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= do_pop;
      if (do_pop) begin
        rsp_ff.data <= que_mem[rd_ptr_ff];
      end
    end
  end

  // ---------------------------------------------------------------
  // Operation-complete arming
  // ---------------------------------------------------------------

  logic opc_armed_ff;
  logic opc_fire;

  assign opc_fire = opc_armed_ff && evt.test_ok;

  // Arming lasts until the test finishes or a reset command drops it.
  // A new completion command in the firing cycle re-arms, so a host
  // that chains tests back to back never loses the second report.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      opc_armed_ff <= 1'b0;
    end else if (is_opc) begin
      opc_armed_ff <= 1'b1;
    end else if (opc_fire || is_rst) begin
      opc_armed_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Event status latch
  // ---------------------------------------------------------------

  logic [7:0] evt_set;
  logic [7:0] evt_clr;
  logic [7:0] nxt_event_status_latch;

  // Set terms per bit; bits 1 and 6 never get a source.
  always_comb begin
    evt_set = ieesr_pkg::BYTE_ZERO;
    evt_set[ieesr_pkg::EVT_OPC] = opc_fire;
    evt_set[ieesr_pkg::EVT_QRY] = lost || empty_rd;
    evt_set[ieesr_pkg::EVT_DEV] = evt.dev_err;
    evt_set[ieesr_pkg::EVT_EXE] = evt.exec_err || psc_bad;
    evt_set[ieesr_pkg::EVT_CMD] = evt.syntax_err ||
                                  (cmd.valid && cmd.unknown);
    evt_set[ieesr_pkg::EVT_PON] = evt.power_on;
    evt_set = evt_set & ieesr_pkg::EVT_USED;
  end

  // Reading the latch clears it as clear-status does, but an event
  // arriving in the same cycle survives so that nothing is lost.
  // The query answer is captured before the clear, so the host sees
  // each event once, in this answer or the next, unless this answer finds the queue full and is thrown away.
  assign evt_clr = {8{is_cls || is_esr_q}};
  assign nxt_event_status_latch =
      (event_status_latch_ff & ~evt_clr) | evt_set;

  // The latch starts with power-on flagged.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      event_status_latch_ff <= ieesr_pkg::EVT_RESET;
    end else begin
      event_status_latch_ff <= nxt_event_status_latch;
    end
  end

  // ---------------------------------------------------------------
  // Enable masks and power-on clear flag
  // ---------------------------------------------------------------

  // A power-on event clears the masks only while the flag is 1.
  // The reset input is a full hard reset and clears them regardless;
  // only the power-on event pulse honours the flag, so a host can keep
  // its masks across a supply dropout by writing the flag to 0.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      event_status_mask_ff <= ieesr_pkg::MASK_RESET;
    end else if (is_ese_w) begin
      event_status_mask_ff <= cmd.arg;
    end else if (evt.power_on && power_on_clear_ff) begin
      event_status_mask_ff <= ieesr_pkg::MASK_RESET;
    end
  end

  // Service request mask; bit 6 is kept but never gates anything.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      service_request_mask_ff <= ieesr_pkg::MASK_RESET;
    end else if (is_sre_w) begin
      service_request_mask_ff <= cmd.arg;
    end else if (evt.power_on && power_on_clear_ff) begin
      service_request_mask_ff <= ieesr_pkg::MASK_RESET;
    end
  end

  // The flag itself survives power-on events; out-of-range is refused.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      power_on_clear_ff <= ieesr_pkg::PSC_RESET;
    end else if (is_psc_w && !psc_bad) begin
      power_on_clear_ff <= cmd.arg[0];
    end
  end

  // ---------------------------------------------------------------
  // Summary status byte and service request
  // ---------------------------------------------------------------

  // Built from current state; registered so the output is a flop.
  // Bit 6 is still zero when the request summary is formed, so the
  // summary can never hold itself up through its own enable bit.
  always_comb begin
    stb_now = ieesr_pkg::BYTE_ZERO;
    stb_now[ieesr_pkg::STB_MAV] = !que_empty;
    stb_now[ieesr_pkg::STB_ESB] =
        |(event_status_latch_ff & event_status_mask_ff);
    mss_now = |(stb_now & service_request_mask_ff);
    stb_now[ieesr_pkg::STB_MSS] = mss_now;
  end

  // One-cycle lag behind the sources it summarises.
  // A host polling the byte right after a command may see the old
  // value for one cycle; the lag buys a flop-driven output.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      summary_status_byte_ff <= ieesr_pkg::BYTE_ZERO;
    end else begin
      summary_status_byte_ff <= stb_now;
    end
  end

  // Pending request: a new request in the clear cycle wins.
  // Only a rising summary sets it; a summary that merely stays high
  // after a clear does not raise a second request for the same cause.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      service_req_ff <= 1'b0;
    end else if (mss_now && !summary_status_byte_ff[ieesr_pkg::STB_MSS]) begin
      service_req_ff <= 1'b1;
    end else if (is_cls) begin
      service_req_ff <= 1'b0;
    end
  end

endmodule

// ### verification/ieesr_chk.sv
// Assertion checker for the status block, bound to its top ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps

module ieesr_chk (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Inputs seen.
  input wire ieesr_pkg::ieesr_cmd_t cmd,
  input wire ieesr_pkg::ieesr_evt_t evt,
  input wire logic rsp_rd,
  // Outputs watched.
  input wire ieesr_pkg::ieesr_rsp_t rsp_ff,
  input wire logic [7:0] event_status_latch_ff,
  input wire logic [7:0] event_status_mask_ff,
  input wire logic [7:0] summary_status_byte_ff,
  input wire logic [7:0] service_request_mask_ff,
  input wire logic service_req_ff
);
  // -------------------------------------------------------------
  // Shorthands
  // -------------------------------------------------------------
  // Valid, recognised commands; a valid unknown one only sets the command error bit.
  wire logic ok = cmd.valid && !cmd.unknown;
  wire logic [7:0] esl = event_status_latch_ff;
  wire logic [7:0] stb = summary_status_byte_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  dev_err_a: assert property (evt.dev_err |=> esl[3])
    else $error("device error not latched");
  exec_err_a: assert property (evt.exec_err |=> esl[4])
    else $error("execution error not latched");
  cmd_err_a: assert property (
    evt.syntax_err || (cmd.valid && cmd.unknown) |=> esl[5])
    else $error("command error not latched");
  ese_store_a: assert property (
    ok && cmd.code == ieesr_pkg::IEESR_CMD_ESE_W && !evt.power_on
    |=> event_status_mask_ff == $past(cmd.arg))
    else $error("event mask not stored");
  sre_store_a: assert property (
    ok && cmd.code == ieesr_pkg::IEESR_CMD_SRE_W && !evt.power_on
    |=> service_request_mask_ff == $past(cmd.arg))
    else $error("service mask not stored");
  cls_clear_a: assert property (
    ok && cmd.code == ieesr_pkg::IEESR_CMD_CLS && evt == '0 && !rsp_rd
    |=> esl == 8'h00)
    else $error("latch not cleared");
  cls_srq_a: assert property (
    ok && cmd.code == ieesr_pkg::IEESR_CMD_CLS
    |=> !service_req_ff || $rose(stb[6]))
    else $error("service request not cleared");
  stb_spare_a: assert property ((stb & 8'h8f) == 8'h00)
    else $error("unassigned summary bit set");
  esb_sum_a: assert property (
    stb[5] == |($past(esl) & $past(event_status_mask_ff)))
    else $error("event summary wrong");
  mss_sum_a: assert property (
    stb[6] == |(stb[5:4] & $past(service_request_mask_ff[5:4])))
    else $error("service summary wrong");
  srq_rise_a: assert property ($rose(service_req_ff) |-> stb[6])
    else $error("service request without summary");
  rsp_pop_a: assert property (rsp_ff.valid |-> $past(rsp_rd))
    else $error("response without read");
endmodule

bind ieesr_status ieesr_chk u_ieesr_chk (.ref_clk, .reset, .cmd, .evt,
  .rsp_rd, .rsp_ff, .event_status_latch_ff, .event_status_mask_ff,
  .summary_status_byte_ff, .service_request_mask_ff, .service_req_ff);

// ### verification/ieesr_host_model.sv
// Host-side model: reads response bytes back as a bus controller.
// Assumes it sees the summary byte and runs on the block's clock.
`timescale 1ns/1ps

module ieesr_host_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Controls from the bench.
  input wire logic rd_en,
  input wire logic poke,
  input wire logic [3:0] lag,
  // Block side.
  input wire logic [7:0] stb,
  output logic rsp_rd
);
  int hold;

  // Pop one byte while data waits; the gap covers the summary lag,
  // so a byte is never popped twice on a stale indication.
  always @(negedge ref_clk or posedge reset) begin
    if (reset) begin
      rsp_rd <= 1'b0;
      hold <= 0;
    end else begin
      rsp_rd <= 1'b0;
      if (hold > 0) begin
        hold <= hold - 1;
      end else if (poke || (rd_en && stb[4])) begin
        rsp_rd <= 1'b1;
        hold <= int'(lag) + 3;
      end
    end
  end
endmodule

// ### verification/ieesr_status_bench.sv
// Self-checking bench for the status block and its host model.
// Assumes the package constants; answers are checked through a queue.
`timescale 1ns/1ps

module ieesr_status_bench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  ieesr_pkg::ieesr_cmd_t cmd = '0;
  ieesr_pkg::ieesr_evt_t evt = '0;
  logic nvm_fail = 1'b0;
  logic rd_en = 1'b1;
  logic poke = 1'b0;
  logic [3:0] lag = 4'h0;
  logic rsp_rd;
  ieesr_pkg::ieesr_rsp_t rsp_ff;
  logic [7:0] esl, event_status_mask, stb, service_request_mask, v;
  logic psc, srq;
  logic [7:0] exp_q[$];
  logic [4:0] ev[4] = '{5'h10, 5'h08, 5'h04, 5'h02};
  logic [7:0] wt[4] = '{8'h08, 8'h10, 8'h20, 8'h00};
  int fails = 0;
  int cmp_count = 0;

  // -------------------------------------------------------------
  // Clock, block and host model
  // -------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  ieesr_status u_ieesr_status (.ref_clk, .reset, .cmd, .evt, .nvm_fail,
    .rsp_rd, .rsp_ff, .event_status_latch_ff(esl),
    .event_status_mask_ff(event_status_mask), .summary_status_byte_ff(stb),
    .service_request_mask_ff(service_request_mask), .power_on_clear_ff(psc),
    .service_req_ff(srq));
  ieesr_host_model u_ieesr_host_model (.ref_clk, .reset, .rd_en, .poke,
    .lag, .stb, .rsp_rd);

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic send(input logic [3:0] c, input logic [7:0] a);
    @(negedge ref_clk);
    cmd <= {1'b1, 1'b0, c, a};
  endtask

  // A query notes its expected answer before it is issued.
  task automatic ask(input logic [3:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    send(c, 8'h00);
  endtask

  task automatic quiet();
    @(negedge ref_clk);
    cmd <= '0;
    evt <= '0;
    poke <= 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic pulse(input logic [4:0] e);
    @(negedge ref_clk);
    evt <= e;
    quiet();
  endtask

  // Bounded wait until every noted answer has come back.
  task automatic drain();
    int n;
    rd_en <= 1'b1;
    for (n = 0; n < 300 && (exp_q.size() != 0 || stb[4] !== 1'b0); n++)
      @(negedge ref_clk);
    if (n == 300) begin
      fails++;
      tally_and_finish();
    end
  endtask

  // Answers are taken mid-cycle, where the popped byte has settled.
  always @(negedge ref_clk) begin
    if (!reset && rsp_ff.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("wrong value at %0t: unexpected answer", $time);
      end else chk8(rsp_ff.data, exp_q.pop_front());
    end
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    void'($urandom(13));
    repeat (8) @(negedge ref_clk);
    reset <= 1'b0;
    chk8(esl, 8'h80);
    chk8({event_status_mask[7:1], psc}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom_range(255));
      lag <= 4'($urandom_range(5));
      send(ieesr_pkg::IEESR_CMD_ESE_W, v);
      ask(ieesr_pkg::IEESR_CMD_ESE_Q, v);
      send(ieesr_pkg::IEESR_CMD_SRE_W, ~v);
      ask(ieesr_pkg::IEESR_CMD_SRE_Q, ~v);
      quiet();
      chk8(event_status_mask, v);
      chk8(service_request_mask, ~v);
      drain();
    end
    nvm_fail <= 1'b1;
    ask(ieesr_pkg::IEESR_CMD_TST_Q, 8'h01);
    quiet();
    nvm_fail <= 1'b0;
    ask(ieesr_pkg::IEESR_CMD_TST_Q, 8'h00);
    quiet();
    drain();
    // Each error event alone, then a stray completion with nothing armed.
    foreach (wt[i]) begin
      send(ieesr_pkg::IEESR_CMD_CLS, 8'h00);
      quiet();
      pulse(ev[i]);
      chk8(esl, wt[i]);
    end
    // A reset command drops the arming; the wait command does nothing.
    send(ieesr_pkg::IEESR_CMD_OPC, 8'h00);
    send(ieesr_pkg::IEESR_CMD_RST, 8'h00);
    send(ieesr_pkg::IEESR_CMD_WAI, 8'h00);
    quiet();
    pulse(5'h02);
    chk8(esl, 8'h00);
    ask(ieesr_pkg::IEESR_CMD_OPC_Q, 8'h01);
    send(ieesr_pkg::IEESR_CMD_OPC, 8'h00);
    quiet();
    pulse(5'h02);
    ask(ieesr_pkg::IEESR_CMD_ESR_Q, 8'h01);
    send(ieesr_pkg::IEESR_CMD_CLS, 8'h00);
    @(negedge ref_clk);
    cmd <= {1'b1, 1'b1, 4'h9, 8'h00};
    quiet();
    drain();
    chk8(esl, 8'h20);
    send(ieesr_pkg::IEESR_CMD_CLS, 8'h00);
    send(ieesr_pkg::IEESR_CMD_ESE_W, 8'h08);
    send(ieesr_pkg::IEESR_CMD_SRE_W, 8'h20);
    quiet();
    pulse(5'h10);
    chk8(stb, 8'h60);
    chk8({7'h0, srq}, 8'h01);
    ask(ieesr_pkg::IEESR_CMD_STB_Q, 8'h60);
    quiet();
    drain();
    send(ieesr_pkg::IEESR_CMD_CLS, 8'h00);
    send(ieesr_pkg::IEESR_CMD_SRE_W, 8'h10);
    quiet();
    chk8({esl[7:1], srq}, 8'h00);
    // Overfill the answer queue while the host stalls.
    rd_en <= 1'b0;
    for (int i = 0; i < 4; i++) ask(ieesr_pkg::IEESR_CMD_ESE_Q, 8'h08);
    send(ieesr_pkg::IEESR_CMD_ESE_Q, 8'h00);
    quiet();
    chk8(esl, 8'h04);
    chk8(stb, 8'h50);
    drain();
    chk8(stb, 8'h00);
    send(ieesr_pkg::IEESR_CMD_CLS, 8'h00);
    quiet();
    @(negedge ref_clk);
    poke <= 1'b1;
    quiet();
    chk8(esl, 8'h04);
    send(ieesr_pkg::IEESR_CMD_PSC_W, 8'h00);
    send(ieesr_pkg::IEESR_CMD_ESE_W, 8'h5a);
    quiet();
    pulse(5'h01);
    chk8(event_status_mask, 8'h5a);
    chk8(esl, 8'h84);
    send(ieesr_pkg::IEESR_CMD_PSC_W, 8'h02);
    send(ieesr_pkg::IEESR_CMD_PSC_W, 8'h01);
    quiet();
    chk8(esl, 8'h94);
    pulse(5'h01);
    chk8({event_status_mask[7:1], psc}, 8'h01);
    ask(ieesr_pkg::IEESR_CMD_PSC_Q, 8'h01);
    quiet();
    drain();
    tally_and_finish();
  end
endmodule
